// ==== design/cphz_pkg.sv ====
// Package for the core sequencing hazard model: instruction classes, offsets, widths.
// Assumes a decoder outside classifies each retired instruction into these classes.
package cphz_pkg;

  // Instruction classes presented once per retire
  typedef enum logic [3:0] {
    CPHZ_OTHER      = 4'h0,
    CPHZ_CALL_SP    = 4'h1,
    CPHZ_LPM_SET    = 4'h2,
    CPHZ_RETURN_FROM_INTERRUPT       = 4'h3,
    CPHZ_XWB_MEM    = 4'h4,
    CPHZ_XPC_WRITE  = 4'h5,
    CPHZ_LPM_IDX    = 4'h6,
    CPHZ_X20_REGREG = 4'h7,
    CPHZ_LPM_BIS    = 4'h8,
    CPHZ_CALLA_REG  = 4'h9,
    CPHZ_NOP        = 4'ha,
    CPHZ_WAKE       = 4'hb
  } cphz_class_t;

  localparam int          ADDR_W      = 20;
  localparam logic [19:0] WORD_STEP   = 20'h00002;
  localparam logic [19:0] PC_RESET    = 20'h00000;
  localparam logic [19:0] SP_RESET    = 20'h00000;
  localparam logic [1:0]  WIDTH_16    = 2'h0;
  localparam logic [1:0]  WIDTH_20    = 2'h1;

endpackage

// ==== design/cphz_core.sv ====
// Behavioural model of the core's sequencing hazards on PC, stack and operand width.
// Assumes one classified instruction per valid strobe, synchronous to CLK.
// How it works
// RULE1: A call through the stack pointer starts execution at SP+2, not at SP.
// RULE2: Software puts a no-op at SP and its routine at SP+2 when calling through SP.
// RULE3: Low power entry directly followed by a return in a nested handler pushes PC+2.
// RULE4: After that nested return the pending return is skipped and the PC runs on from the bad value.
// RULE5: Software puts a no-op between low power entry and a directly following return.
// RULE6: An extended write-back followed at once by an extended PC write executes the second wrongly.
// RULE7: Software separates those two with a no-op or avoids extended PC writes.
// RULE8: A pending NMI at indexed low power entry followed by a 20-bit reg-reg op runs the handler's first op at 20 bits.
// RULE9: Software follows indexed low power entry with a no-op or starts the NMI handler with one.
// RULE10: Bit-set low power entry then register extended call with the DMA block bit set holds DMA off all low power.
// RULE11: Software may clear the DMA block bit across low power entry and restore it after.
// RULE12: All other sequences behave with normal architectural semantics.
`timescale 1ns/1ns
module cphz_core
  import cphz_pkg::*;
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_N,
  // Retired instruction stream
  input  wire logic                INSN_VALID,
  input  wire cphz_pkg::cphz_class_t INSN_CLASS,
  input  wire logic [19:0]         INSN_PC,
  input  wire logic [19:0]         INSN_SP,
  input  wire logic [19:0]         RETURN_ADDR,
  // Core status
  input  wire logic                GLOBAL_INTERRUPT_ENABLE,
  input  wire logic                IN_HANDLER,
  input  wire logic                NESTED_IRQ,
  input  wire logic                NMI_PENDING,
  input  wire logic                DMA_RMW_BLOCK_BIT,
  // Model results
  output logic [19:0]              NEXT_PC,
  output logic [19:0]              PUSHED_PC,
  output logic                     PUSH_VALID,
  output logic                     SKIP_RETURN_FROM_INTERRUPT,
  output logic                     BAD_EXEC,
  output logic [1:0]               HANDLER_WIDTH,
  output logic                     DMA_HOLD
);
  import cphz_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence history state
  cphz_class_t prev_q, prev_d;
  logic        lpm_idx_q, lpm_idx_d;
  logic        bis_q, bis_d;
  logic        prev_lpm;
  logic [19:0] next_pc_q, next_pc_d;
  logic [19:0] pushed_q, pushed_d;
  logic        push_q, push_d;
  logic        skip_q, skip_d;
  logic        bad_q, bad_d;
  logic [1:0]  width_q, width_d;
  logic        dma_q, dma_d;

  // Any low power entry class retired just before
  assign prev_lpm = (prev_q == CPHZ_LPM_SET) || (prev_q == CPHZ_LPM_IDX)
                    || (prev_q == CPHZ_LPM_BIS); // RULE3

  // Next state of the hazard model
  always_comb begin
    prev_d     = prev_q;
    lpm_idx_d  = lpm_idx_q;
    bis_d      = bis_q;
    next_pc_d  = next_pc_q;
    pushed_d   = pushed_q;
    push_d     = 1'b0;
    skip_d     = 1'b0;
    bad_d      = 1'b0;
    width_d    = width_q;
    dma_d      = dma_q;
    if (INSN_VALID) begin
      prev_d    = INSN_CLASS;
      next_pc_d = INSN_PC + WORD_STEP; // RULE12
      case (INSN_CLASS)
        CPHZ_CALL_SP: begin
          next_pc_d = INSN_SP + WORD_STEP; // RULE1
        end
        CPHZ_RETURN_FROM_INTERRUPT: begin
          if (prev_lpm && IN_HANDLER && GLOBAL_INTERRUPT_ENABLE && NESTED_IRQ) begin
            pushed_d   = INSN_PC + WORD_STEP; // RULE3
            push_d     = 1'b1;
            next_pc_d  = INSN_PC + WORD_STEP; // RULE4
            skip_d     = 1'b1;
          end else begin
            next_pc_d = RETURN_ADDR;
          end
        end
        CPHZ_XPC_WRITE: begin
          bad_d = (prev_q == CPHZ_XWB_MEM); // RULE6
        end
        CPHZ_X20_REGREG: begin
          if (lpm_idx_q && prev_q == CPHZ_LPM_IDX && NMI_PENDING) begin
            width_d = WIDTH_20; // RULE8
          end else begin
            width_d = WIDTH_16; // RULE12
          end
        end
        CPHZ_CALLA_REG: begin
          if (bis_q && prev_q == CPHZ_LPM_BIS && DMA_RMW_BLOCK_BIT) begin
            dma_d = 1'b1; // RULE10
          end
        end
        CPHZ_WAKE: begin
          dma_d      = 1'b0;
        end
        default: begin
          width_d = WIDTH_16; // RULE12
        end
      endcase
      lpm_idx_d = (INSN_CLASS == CPHZ_LPM_IDX);
      bis_d     = (INSN_CLASS == CPHZ_LPM_BIS);
    end
  end

  // Register the model state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_q     <= CPHZ_OTHER;
      lpm_idx_q  <= 1'b0;
      bis_q      <= 1'b0;
      next_pc_q  <= PC_RESET;
      pushed_q   <= SP_RESET;
      push_q     <= 1'b0;
      skip_q     <= 1'b0;
      bad_q      <= 1'b0;
      width_q    <= WIDTH_16;
      dma_q      <= 1'b0;
    end else begin
      prev_q     <= prev_d;
      lpm_idx_q  <= lpm_idx_d;
      bis_q      <= bis_d;
      next_pc_q  <= next_pc_d;
      pushed_q   <= pushed_d;
      push_q     <= push_d;
      skip_q     <= skip_d;
      bad_q      <= bad_d;
      width_q    <= width_d;
      dma_q      <= dma_d;
    end
  end

  // Outputs straight from flip-flops
  assign NEXT_PC       = next_pc_q;
  assign PUSHED_PC     = pushed_q;
  assign PUSH_VALID    = push_q;
  assign SKIP_RETURN_FROM_INTERRUPT     = skip_q;
  assign BAD_EXEC      = bad_q;
  assign HANDLER_WIDTH = width_q;
  assign DMA_HOLD      = dma_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Hazard sequences show their faults one edge after the taken instruction
  a_call_sp_target: assert property (@(posedge CLK) disable iff (!RST_N) // RULE1
    INSN_VALID && INSN_CLASS == CPHZ_CALL_SP |=> NEXT_PC == $past(INSN_SP) + WORD_STEP)
    else $error("call through SP did not start at SP+2");
  a_nested_push: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
    INSN_VALID && INSN_CLASS == CPHZ_RETURN_FROM_INTERRUPT && prev_q == CPHZ_LPM_SET && IN_HANDLER
      && GLOBAL_INTERRUPT_ENABLE && NESTED_IRQ |=> PUSH_VALID && PUSHED_PC == $past(INSN_PC) + WORD_STEP)
    else $error("nested push did not hold PC+2");
  a_return_from_interrupt_skip: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
    PUSH_VALID |-> SKIP_RETURN_FROM_INTERRUPT && NEXT_PC == PUSHED_PC)
    else $error("pending return not skipped");
  a_xpc_bad: assert property (@(posedge CLK) disable iff (!RST_N) // RULE6
    INSN_VALID && INSN_CLASS == CPHZ_XPC_WRITE && prev_q == CPHZ_XWB_MEM |=> BAD_EXEC)
    else $error("extended PC write after write-back not flagged");
  a_xpc_sep: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    BAD_EXEC |-> $past(prev_q) == CPHZ_XWB_MEM)
    else $error("bad execution flagged without cause");
  a_nmi_width: assert property (@(posedge CLK) disable iff (!RST_N) // RULE8
    INSN_VALID && INSN_CLASS == CPHZ_X20_REGREG && prev_q == CPHZ_LPM_IDX && NMI_PENDING
      |=> HANDLER_WIDTH == WIDTH_20)
    else $error("handler width not 20 bits");
  a_dma_hold: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
    INSN_VALID && INSN_CLASS == CPHZ_CALLA_REG && prev_q == CPHZ_LPM_BIS && DMA_RMW_BLOCK_BIT
      |=> DMA_HOLD)
    else $error("DMA not held in low power");
  a_dma_release: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    INSN_VALID && INSN_CLASS == CPHZ_WAKE |=> !DMA_HOLD)
    else $error("DMA hold survived wake");
  a_normal_step: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    INSN_VALID && INSN_CLASS == CPHZ_OTHER |=> NEXT_PC == $past(INSN_PC) + WORD_STEP && !BAD_EXEC)
    else $error("ordinary instruction did not step PC");

  // Outside the hazard a return takes the stacked address and pushes nothing
  a_return_from_interrupt_normal: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    INSN_VALID && INSN_CLASS == CPHZ_RETURN_FROM_INTERRUPT && !(prev_lpm && IN_HANDLER && GLOBAL_INTERRUPT_ENABLE && NESTED_IRQ)
      |=> NEXT_PC == $past(RETURN_ADDR) && !PUSH_VALID && !SKIP_RETURN_FROM_INTERRUPT)
    else $error("plain return did not take the stacked address");

  // Result pulses only follow a taken instruction
  a_pulse_quiet: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    !INSN_VALID |=> !PUSH_VALID && !SKIP_RETURN_FROM_INTERRUPT && !BAD_EXEC)
    else $error("result pulse without a taken instruction");

  // Idle cycles keep every level output
  a_idle_hold: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    !INSN_VALID |=> $stable(NEXT_PC) && $stable(PUSHED_PC) && $stable(HANDLER_WIDTH) && $stable(DMA_HOLD))
    else $error("level output moved on an idle cycle");

  // The DMA hold lasts until wake
  a_dma_keep: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
    DMA_HOLD && !(INSN_VALID && INSN_CLASS == CPHZ_WAKE) |=> DMA_HOLD)
    else $error("DMA hold dropped before wake");

  // A skipped return only follows a nested return
  a_skip_cause: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
    SKIP_RETURN_FROM_INTERRUPT |-> $past(INSN_VALID) && $past(INSN_CLASS) == CPHZ_RETURN_FROM_INTERRUPT && $past(NESTED_IRQ))
    else $error("return skipped without a nested return");

  // A no-op clears the widened handler width
  a_width_clear: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    INSN_VALID && INSN_CLASS == CPHZ_NOP |=> HANDLER_WIDTH == WIDTH_16)
    else $error("no-op left the handler width widened");

  // A register op widens nothing unless indexed low power entry came just before
  a_width_cause: assert property (@(posedge CLK) disable iff (!RST_N) // RULE8
    INSN_VALID && INSN_CLASS == CPHZ_X20_REGREG && prev_q != CPHZ_LPM_IDX |=> HANDLER_WIDTH == WIDTH_16)
    else $error("register op widened the handler without cause");
endmodule

// ==== testbench/cphz_core_test.sv ====
// Self-checking bench for the core sequencing hazard model.
// Assumes the package classes and one output update one edge after a taken instruction.
`timescale 1ns/1ns
module cphz_core_test;
  import cphz_pkg::*;
  `define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, a); end end
  logic        clk  = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld  = 1'b0;
  cphz_class_t cls  = CPHZ_OTHER;
  logic [19:0] ipc  = 20'h00000;
  logic [19:0] isp  = 20'h00400;
  logic [19:0] ret  = 20'h00800;
  logic        global_interrupt_enable  = 1'b0;
  logic        inh  = 1'b0;
  logic        nest = 1'b0;
  logic        nmi  = 1'b0;
  logic        dma  = 1'b0;
  logic [19:0] npc, ppc;
  logic        pv, skip, bad, hold;
  logic [1:0]  wid;
  int          fails = 0;
  int          cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and device under test
  always #5 clk = ~clk;
  cphz_core uut (.CLK(clk), .RST_N(rst_n), .INSN_VALID(vld), .INSN_CLASS(cls), .INSN_PC(ipc), .INSN_SP(isp),
    .RETURN_ADDR(ret), .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .IN_HANDLER(inh), .NESTED_IRQ(nest), .NMI_PENDING(nmi),
    .DMA_RMW_BLOCK_BIT(dma), .NEXT_PC(npc), .PUSHED_PC(ppc), .PUSH_VALID(pv), .SKIP_RETURN_FROM_INTERRUPT(skip),
    .BAD_EXEC(bad), .HANDLER_WIDTH(wid), .DMA_HOLD(hold));
  ////////////////////////////////////////////////////////////////////////////////
  // One instruction with status {gie, in handler, nested, nmi, dma}; returns while one-cycle results stand
  task automatic op(input cphz_class_t c, input logic [19:0] pc, input logic [4:0] st);
    @(posedge clk);
    vld <= 1'b1;
    cls <= c;
    ipc <= pc;
    {global_interrupt_enable, inh, nest, nmi, dma} <= st;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  // Ordinary instruction steps the PC and flags nothing
  task automatic t_plain();
    op(CPHZ_OTHER, 20'h00900, 5'h00);
    `CHK("next_pc", 20'h00902, npc)
    `CHK("bad_exec", 1'b0, bad)
    $display("test plain_step done");
  endtask
  // Call through the stack pointer
  task automatic t_call();
    op(CPHZ_CALL_SP, 20'h00100, 5'h00);
    `CHK("next_pc", 20'h00402, npc)
    $display("test call_sp done");
  endtask
  // Low power then return inside a nested handler, plain and with a no-op between
  task automatic t_nest();
    op(CPHZ_LPM_SET, 20'h00100, 5'h18);
    op(CPHZ_RETURN_FROM_INTERRUPT, 20'h00102, 5'h1c);
    `CHK("push_valid", 1'b1, pv)
    `CHK("pushed_pc", 20'h00104, ppc)
    `CHK("skip_return_from_interrupt", 1'b1, skip)
    `CHK("next_pc", 20'h00104, npc)
    op(CPHZ_LPM_IDX, 20'h00300, 5'h18);
    op(CPHZ_RETURN_FROM_INTERRUPT, 20'h00302, 5'h1c);
    `CHK("push_valid", 1'b1, pv)
    `CHK("pushed_pc", 20'h00304, ppc)
    op(CPHZ_LPM_SET, 20'h00200, 5'h18);
    op(CPHZ_NOP, 20'h00202, 5'h18);
    op(CPHZ_RETURN_FROM_INTERRUPT, 20'h00204, 5'h1c);
    `CHK("push_valid", 1'b0, pv)
    `CHK("skip_return_from_interrupt", 1'b0, skip)
    `CHK("next_pc", 20'h00800, npc)
    $display("test nested_return done");
  endtask
  // Extended write-back then extended PC write
  task automatic t_xpc();
    op(CPHZ_XWB_MEM, 20'h00300, 5'h00);
    op(CPHZ_XPC_WRITE, 20'h00304, 5'h00);
    `CHK("bad_exec", 1'b1, bad)
    op(CPHZ_XWB_MEM, 20'h00310, 5'h00);
    op(CPHZ_NOP, 20'h00314, 5'h00);
    op(CPHZ_XPC_WRITE, 20'h00316, 5'h00);
    `CHK("bad_exec", 1'b0, bad)
    $display("test ext_pc_write done");
  endtask
  // Indexed low power entry with pending NMI then 20-bit register op
  task automatic t_nmi();
    op(CPHZ_LPM_IDX, 20'h00400, 5'h02);
    op(CPHZ_X20_REGREG, 20'h00404, 5'h02);
    `CHK("handler_width", WIDTH_20, wid)
    op(CPHZ_LPM_IDX, 20'h00410, 5'h02);
    op(CPHZ_NOP, 20'h00414, 5'h02);
    op(CPHZ_X20_REGREG, 20'h00416, 5'h02);
    `CHK("handler_width", WIDTH_16, wid)
    $display("test nmi_width done");
  endtask
  // Bit-set low power then register extended call, block bit set and cleared
  task automatic t_dma();
    op(CPHZ_LPM_BIS, 20'h00500, 5'h01);
    op(CPHZ_CALLA_REG, 20'h00504, 5'h01);
    `CHK("dma_hold", 1'b1, hold)
    op(CPHZ_WAKE, 20'h00600, 5'h01);
    `CHK("dma_hold", 1'b0, hold)
    op(CPHZ_LPM_BIS, 20'h00700, 5'h00);
    op(CPHZ_CALLA_REG, 20'h00704, 5'h00);
    `CHK("dma_hold", 1'b0, hold)
    $display("test dma_hold done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("reset next_pc", PC_RESET, npc)
    `CHK("reset handler_width", WIDTH_16, wid)
    `CHK("reset dma_hold", 1'b0, hold)
    t_plain();
    t_call();
    t_nest();
    t_xpc();
    t_nmi();
    t_dma();
    tally_and_finish();
  end
endmodule
